/* File: logic/otu_fault_counter.sv */
// Saturating up/down counter that filters window comparison results.
// Assumes step is a single-cycle decision on clk_sys and clear a level that holds the count at reset.
`timescale 1ns/100ps
`default_nettype none
module otu_fault_counter
	import otu_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               arst_n,
	input  wire logic               clear,
	input  wire logic               step,
	input  wire logic               up,
	output var  logic [FAULT_W-1:0] count
);

	localparam logic [FAULT_W-1:0] CNT_MAX = FAULT_W'(FAULT_MAX);
	localparam logic [FAULT_W-1:0] CNT_ONE = 7'h01;

	wire logic at_max = (count == CNT_MAX);
	wire logic at_min = (count == FAULT_RESET);

	wire logic [FAULT_W-1:0] next_count =
		clear                    ? FAULT_RESET :
		(step && up && !at_max)  ? count + CNT_ONE :
		(step && !up && !at_min) ? count - CNT_ONE :
		count;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count <= FAULT_RESET;
		end else begin
			count <= next_count;
		end
	end

endmodule : otu_fault_counter
`default_nettype wire

/* File: logic/otu_pkg.sv */
// Shared constants and types of the oscillator training unit.
// Assumes a single 125 MHz system clock taken from the trained oscillator.
package otu_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int TRAIN_INTERVAL_US = 4000;
	localparam int CLK_MHZ           = 125;
	localparam int TYP_CYCLES        = TRAIN_INTERVAL_US * CLK_MHZ;
	localparam int CRM_MIN_US        = 500;
	localparam int CRM_MAX_US        = 4000;
	localparam int STARTUP_US        = 1000;
	localparam int STARTUP_CYCLES    = STARTUP_US * CLK_MHZ;

	////////////////////////////////////////////////////////////////////////////////
	// Field widths and limits.
	localparam int PER_W       = 16;
	localparam int PDCM_CODES  = 8;
	localparam int CRM_CODES   = 4;
	localparam int N_W         = 8;
	localparam int MIN_PER_US  = 16;
	localparam int FAULT_W     = 7;
	localparam int FAULT_MAX   = 127;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [FAULT_W-1:0] FAULT_RESET = 7'h00;
	localparam logic               FLAG_RESET  = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Modes and states.
	typedef enum logic [2:0] {
		MODE_DSI3_CRM,
		MODE_DSI3_PDCM,
		MODE_PSI5,
		MODE_SPI,
		MODE_I2C
	} otu_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_MEASURE
	} otu_state_t;

endpackage : otu_pkg

/* File: logic/otu_trainer.sv */
// Oscillator training unit: measures local cycles over the master's periodic traffic.
// Assumes period_event and blocking_end are one-cycle pulses from decoders on clk_sys.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - When enabled, measure master traffic against the selected period fields.
// - Derive the expected number of master periods per 4 ms interval.
// - Command/response mode trains only for periods from 500 us to 4 ms.
// - Count local cycles across the expected number of master periods.
// - Adjust only when the measured count lies inside the acceptance window.
// - Count above typical plus deadband lowers the target one trim step.
// - Count below typical minus deadband raises the target one trim step.
// - DSI3 and PSI5 apply the new target at command blocking end.
// - SPI and I2C apply the new target as soon as decided.
// - Enable cleared with revert clear holds the last adjustment.
// - Enable cleared with revert set restores the untrained setting.
// - PSI5 reference is the sync pulse period in the periodic field.
// - PSI5 training mutes phase 1 sync replies and starts after startup delay.
// - SPI training is timed from source id zero sensor data requests.
// - I2C training is timed from reads of the first sensor low byte.
// - Fault counter counts up outside the window, down inside it.
// - Fault counter reaching the limit sets the training fault flag.
// - Fault counter saturates between 0 and 127.
// - Command/response period outside 500 us to 4 ms sets the fault flag.
// - Command/response period not dividing 4 ms sets the fault flag.
module otu_trainer
	import otu_pkg::*;
#(
	parameter int                            CNT_W        = 21,
	parameter int                            TRIM_W       = 8,
	parameter int                            TYP_COUNT    = TYP_CYCLES,
	parameter int                            WINDOW       = 5000,
	parameter int                            DEADBAND     = 250,
	parameter int                            TRIM_STEP    = 1,
	parameter int                            STARTUP_CNT  = STARTUP_CYCLES,
	parameter logic [PDCM_CODES*PER_W-1:0]   PDCM_TABLE   =
		{16'h0bb8, 16'h0064, 16'h007d, 16'h00fa, 16'h0fa0, 16'h07d0, 16'h03e8, 16'h01f4},
	parameter logic [CRM_CODES*PER_W-1:0]    CRM_TABLE    =
		{16'h0fa0, 16'h07d0, 16'h03e8, 16'h01f4}
)(
	input  wire logic                     clk_sys,
	input  wire logic                     arst_n,
	input  wire logic                     training_enable,
	input  wire logic                     training_revert,
	input  wire otu_mode_t                link_mode,
	input  wire logic [1:0]               command_period_sel,
	input  wire logic [2:0]               periodic_period_sel,
	input  wire logic [FAULT_W-1:0]       fault_count_limit,
	input  wire logic                     fault_clear,
	input  wire logic                     period_event,
	input  wire logic                     blocking_end,
	input  wire logic                     psi5_phase1,
	output var  logic signed [TRIM_W-1:0] trim_offset,
	output var  logic                     training_fault_flag,
	output logic          [FAULT_W-1:0]   fault_count,
	output var  logic     [CNT_W-1:0]     measured_count,
	output var  logic                     measure_done,
	output var  logic                     sync_reply_block,
	output var  logic                     training_active
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks.
	localparam int TRIM_MAX_I = (2 ** (TRIM_W - 1)) - 1;
	localparam int STARTUP_W  = $clog2(STARTUP_CNT + 1);

	if (2 ** CNT_W <= TYP_COUNT + WINDOW + 1) begin : g_bad_cnt
		$error("Cycle counter too narrow for the typical count.");
	end
	if (TRIM_STEP < 1 || TRIM_STEP > TRIM_MAX_I) begin : g_bad_step
		$error("Trim step does not fit the trim offset width.");
	end
	if (DEADBAND > WINDOW || STARTUP_CNT < 1) begin : g_bad_win
		$error("Deadband exceeds window or startup count is zero.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Period decoding.
	function automatic int n_of(input int per_us);
		return (per_us >= MIN_PER_US) ? TRAIN_INTERVAL_US / per_us : 0;
	endfunction : n_of

	function automatic logic crm_legal(input int per_us);
		return (per_us >= CRM_MIN_US) && (per_us <= CRM_MAX_US) &&
			((TRAIN_INTERVAL_US % per_us) == 0);
	endfunction : crm_legal

	logic [N_W-1:0] pdcm_n [PDCM_CODES];
	logic [N_W-1:0] crm_n  [CRM_CODES];
	logic           crm_ok [CRM_CODES];

	for (genvar g = 0; g < PDCM_CODES; g++) begin : g_pdcm
		localparam int PER = int'(PDCM_TABLE[g*PER_W +: PER_W]);
		if (PER < MIN_PER_US) begin : g_bad
			$error("Periodic period entry below the minimum period.");
		end
		assign pdcm_n[g] = N_W'(n_of(PER));
	end
	for (genvar g = 0; g < CRM_CODES; g++) begin : g_crm
		localparam int PER = int'(CRM_TABLE[g*PER_W +: PER_W]);
		if (PER < MIN_PER_US) begin : g_bad
			$error("Command period entry below the minimum period.");
		end
		assign crm_n[g]  = N_W'(n_of(PER));
		assign crm_ok[g] = crm_legal(PER);
	end

	wire logic mode_crm  = (link_mode == MODE_DSI3_CRM);
	wire logic mode_psi5 = (link_mode == MODE_PSI5);
	wire logic immediate = (link_mode == MODE_SPI) || (link_mode == MODE_I2C);

	wire logic [N_W-1:0] sel_n  = mode_crm ? crm_n[command_period_sel]
		: pdcm_n[periodic_period_sel];
	wire logic           crm_bad = mode_crm && !crm_ok[command_period_sel];

	////////////////////////////////////////////////////////////////////////////////
	// PSI5 startup delay.
	localparam logic [STARTUP_W-1:0] STARTUP_END = STARTUP_W'(STARTUP_CNT);
	localparam logic [STARTUP_W-1:0] STARTUP_ONE = STARTUP_W'(1);

	logic [STARTUP_W-1:0] startup_cnt;
	logic                 startup_done;

	// The counter stops once done, so the delay is served only once per reset.
	// startup delay after reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			startup_cnt  <= '0;
			startup_done <= 1'b0;
		end else if (!startup_done) begin
			startup_cnt  <= startup_cnt + STARTUP_ONE;
			startup_done <= (startup_cnt + STARTUP_ONE == STARTUP_END);
		end
	end

	wire logic train_go = training_enable && !crm_bad && (sel_n != '0) &&
		(!mode_psi5 || startup_done);

	////////////////////////////////////////////////////////////////////////////////
	// Measurement state machine.
	localparam logic [CNT_W-1:0] CYC_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CYC_ONE = CNT_W'(1);
	localparam logic [N_W-1:0]   EV_ONE  = N_W'(1);
	localparam logic [CNT_W-1:0] WIN_LO  = CNT_W'((TYP_COUNT > WINDOW) ? TYP_COUNT - WINDOW : 0);
	localparam logic [CNT_W-1:0] WIN_HI  = CNT_W'(TYP_COUNT + WINDOW);
	localparam logic [CNT_W-1:0] ADJ_LO  = CNT_W'((TYP_COUNT > DEADBAND) ? TYP_COUNT - DEADBAND : 0);
	localparam logic [CNT_W-1:0] ADJ_HI  = CNT_W'(TYP_COUNT + DEADBAND);

	otu_state_t     state;
	otu_state_t     next_state;
	logic [CNT_W-1:0] cyc;
	logic [N_W-1:0]   evcnt;

	wire logic [CNT_W-1:0] cyc_inc   = (cyc == CYC_MAX) ? cyc : cyc + CYC_ONE;
	wire logic [N_W-1:0]   evcnt_inc = evcnt + EV_ONE;

	wire logic event_ok = (state == ST_MEASURE) && train_go && period_event;
	wire logic decision = event_ok && (evcnt_inc == sel_n);

	wire logic in_win   = (cyc_inc >= WIN_LO) && (cyc_inc <= WIN_HI);
	wire logic too_high = cyc_inc > ADJ_HI;
	wire logic too_low  = cyc_inc < ADJ_LO;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:    next_state = train_go ? ST_ARM : ST_IDLE;
			ST_ARM:     next_state = !train_go ? ST_IDLE : (period_event ? ST_MEASURE : ST_ARM);
			ST_MEASURE: next_state = train_go ? ST_MEASURE : ST_IDLE;
			default:    next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			cyc   <= '0;
			evcnt <= '0;
		end else begin
			state <= next_state;
			cyc   <= (state != ST_MEASURE || decision) ? '0 : cyc_inc;
			evcnt <= (state != ST_MEASURE || decision) ? '0 : (event_ok ? evcnt_inc : evcnt);
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			measured_count <= '0;
			measure_done   <= 1'b0;
		end else begin
			measured_count <= decision ? cyc_inc : measured_count;
			measure_done   <= decision;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trim target.
	localparam logic signed [TRIM_W:0] STEP_X = (TRIM_W+1)'(TRIM_STEP);
	localparam logic signed [TRIM_W:0] MAX_X  = (TRIM_W+1)'(TRIM_MAX_I);
	localparam logic signed [TRIM_W:0] MIN_X  = -MAX_X - STEP_X + STEP_X - (TRIM_W+1)'(1);

	logic enable_q;
	logic started;
	logic pend_valid;
	logic pend_dn;

	wire logic enable_fall = enable_q && !training_enable && started;

	wire logic signed [TRIM_W:0] trim_ext = {trim_offset[TRIM_W-1], trim_offset};
	wire logic signed [TRIM_W:0] trim_dn  = trim_ext - STEP_X;
	wire logic signed [TRIM_W:0] trim_up  = trim_ext + STEP_X;
	wire logic signed [TRIM_W-1:0] trim_dn_sat =
		(trim_dn < MIN_X) ? MIN_X[TRIM_W-1:0] : trim_dn[TRIM_W-1:0];
	wire logic signed [TRIM_W-1:0] trim_up_sat =
		(trim_up > MAX_X) ? MAX_X[TRIM_W-1:0] : trim_up[TRIM_W-1:0];

	wire logic apply_now = decision && in_win && immediate;
	wire logic apply_blk = blocking_end && pend_valid && !immediate && training_enable;
	wire logic apply_dn  = (apply_now && too_high) || (apply_blk && pend_dn);
	wire logic apply_up  = (apply_now && too_low) || (apply_blk && !pend_dn);
	wire logic pend_set  = decision && in_win && !immediate && (too_high || too_low);

	wire logic signed [TRIM_W-1:0] next_trim =
		(enable_fall && training_revert) ? '0 :
		apply_dn ? trim_dn_sat :
		apply_up ? trim_up_sat :
		trim_offset;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			trim_offset <= '0;
			enable_q    <= 1'b0;
			started     <= 1'b0;
			pend_valid  <= 1'b0;
			pend_dn     <= 1'b0;
		end else begin
			trim_offset <= next_trim;
			enable_q    <= training_enable;
			started     <= training_enable ? (started || state != ST_IDLE) : 1'b0;
			pend_valid  <= pend_set || (pend_valid && !apply_blk && !enable_fall);
			pend_dn     <= pend_set ? too_high : pend_dn;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault filtering and status.
	otu_fault_counter u_fault (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.clear   (!training_enable),
		.step    (decision),
		.up      (!in_win),
		.count   (fault_count)
	);

	wire logic limit_hit = training_enable && (fault_count >= fault_count_limit);
	wire logic cfg_err   = training_enable && crm_bad;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			training_fault_flag <= FLAG_RESET;
			sync_reply_block    <= 1'b0;
			training_active     <= 1'b0;
		end else begin
			training_fault_flag <= limit_hit || cfg_err || (training_fault_flag && !fault_clear);
			sync_reply_block    <= training_enable && mode_psi5 && psi5_phase1;
			training_active     <= (next_state != ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_fall_revert;
		enable_fall && training_revert;
	endsequence

	a_fault_sat: assert property (decision
		&& (in_win ? fault_count == 7'h00 : fault_count == 7'h7f) |=> $stable(fault_count))
		else $error("Fault counter left its saturation bound.");
	a_fault_up: assert property (decision && !in_win && fault_count != 7'h7f
		|=> fault_count == $past(fault_count) + 7'h01)
		else $error("Fault counter did not count up.");
	a_fault_down: assert property (decision && in_win && fault_count != 7'h00
		|=> fault_count == $past(fault_count) - 7'h01)
		else $error("Fault counter did not count down.");
	a_flag_sticky: assert property (training_fault_flag && !fault_clear
		|=> training_fault_flag)
		else $error("Fault flag dropped without a clear.");
	a_fault_flag: assert property (limit_hit |=> training_fault_flag)
		else $error("Fault flag not set at limit.");
	a_crm_flag: assert property (cfg_err |=> training_fault_flag && state == ST_IDLE)
		else $error("Bad command period not flagged.");
	a_no_adjust: assert property (decision && !in_win && immediate |=> $stable(trim_offset))
		else $error("Trim changed outside window.");
	a_step_down: assert property (decision && in_win && immediate && too_high
		&& trim_dn >= MIN_X |=> trim_offset == $past(trim_dn[TRIM_W-1:0]))
		else $error("Trim not lowered by one step.");
	a_step_up: assert property (decision && in_win && immediate && too_low
		&& trim_up <= MAX_X |=> trim_offset == $past(trim_up[TRIM_W-1:0]))
		else $error("Trim not raised by one step.");
	a_wait_block: assert property (pend_set && !blocking_end |=> $stable(trim_offset)
		##0 pend_valid)
		else $error("Trim applied before blocking end.");
	a_apply_block: assert property (apply_blk && pend_dn
		|=> trim_offset == $past(trim_dn_sat))
		else $error("Pending step not applied at blocking end.");
	a_revert_zero: assert property (s_fall_revert |=> trim_offset == '0 ##1 !pend_valid)
		else $error("Trim not reverted.");
	a_hold_trim: assert property (enable_fall && !training_revert |=> $stable(trim_offset))
		else $error("Trim not held after disable.");
	a_psi5_mute: assert property (training_enable && mode_psi5 && psi5_phase1
		|=> sync_reply_block)
		else $error("Sync reply not blocked in phase one.");
	a_psi5_wait: assert property (mode_psi5 && !startup_done |=> !training_active)
		else $error("Training started before the startup delay.");
	a_measure_cnt: assert property (decision |=> measured_count == $past(cyc_inc)
		&& measure_done)
		else $error("Measured count not latched.");

endmodule : otu_trainer
`default_nettype wire

/* File: sim/otu_master_model.sv */
// Model of the bus master: periodic traffic events and command blocking ends.
// Assumes the bench changes the period only just after an event.
`timescale 1ns/100ps
`default_nettype none
module otu_master_model (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic [9:0] period_cycles,
	input  wire logic [3:0] block_delay,
	output var  logic       period_event,
	output var  logic       blocking_end
);
	logic [9:0] cnt;
	logic [3:0] blk;
	logic       fire;
	////////////////////////////////////////////////////////////
	// steady master period.
	assign fire = run && (cnt == period_cycles - 10'h001);
	// Falling edge keeps events away from the trainer's sampling edge.
	always_ff @(negedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt          <= 10'h000;
			blk          <= 4'h0;
			period_event <= 1'b0;
			blocking_end <= 1'b0;
		end else begin
			period_event <= fire;
			blocking_end <= (blk == 4'h1);
			cnt          <= (fire || !run) ? 10'h000 : cnt + 10'h001;
			blk          <= fire ? block_delay : ((blk != 4'h0) ? blk - 4'h1 : 4'h0);
		end
	end
endmodule : otu_master_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the oscillator training unit with a master model.
// Assumes shortened typical count and startup delay; periods in table microseconds.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import otu_pkg::*;
	localparam int TYP = 200;
	localparam int WIN = 40;
	localparam int DB  = 10;
	logic               clk_sys, arst_n, training_enable, training_revert;
	logic               fault_clear, period_event, blocking_end, psi5_phase1;
	logic               training_fault_flag, measure_done, sync_reply_block;
	logic               training_active, run;
	otu_mode_t          link_mode;
	logic [1:0]         command_period_sel;
	logic [2:0]         periodic_period_sel;
	logic [6:0]         fault_count_limit, fault_count;
	logic signed [7:0]  trim_offset, exp_trim, nt;
	logic [20:0]        measured_count;
	logic [9:0]         period_cycles;
	logic [3:0]         block_delay;
	logic               exp_flag;
	int                 seed = 20;
	int                 error_cnt = 0;
	int                 samples_checked = 0;
	int                 exp_fault;
	int                 corner[4] = '{40, -48, 8, -40};

	otu_trainer #(.TYP_COUNT(TYP), .WINDOW(WIN), .DEADBAND(DB), .STARTUP_CNT(20),
		.CRM_TABLE({16'h0bb8, 16'h00fa, 16'h03e8, 16'h01f4})) i_otu_trainer (
		.clk_sys, .arst_n, .training_enable, .training_revert, .link_mode,
		.command_period_sel, .periodic_period_sel, .fault_count_limit, .fault_clear,
		.period_event, .blocking_end, .psi5_phase1, .trim_offset, .training_fault_flag,
		.fault_count, .measured_count, .measure_done, .sync_reply_block, .training_active);

	otu_master_model i_otu_master_model (.clk_sys, .arst_n, .run, .period_cycles,
		.block_delay, .period_event, .blocking_end);

	////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	function automatic int per_us(input logic [2:0] c);
		case (c)
			3'h0: return 500;
			3'h1: return 1000;
			3'h2: return 2000;
			3'h4: return 250;
			3'h5: return 125;
			3'h6: return 100;
			3'h7: return 3000;
			default: return 4000;
		endcase
	endfunction : per_us

	function automatic logic signed [7:0] next_trim(input int m, input logic signed [7:0] t);
		if (m < TYP - WIN || m > TYP + WIN) return t;
		if (m > TYP + DB) return t - 8'sh01;
		if (m < TYP - DB) return t + 8'sh01;
		return t;
	endfunction : next_trim

	task automatic end_of_test;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	// The bound stands far above the longest interval used here.
	task automatic wait_done;
		int k;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (measure_done !== 1'b1 && k < 2000);
		if (k >= 2000) begin
			error_cnt++;
			end_of_test();
		end
	endtask : wait_done

	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////
	initial begin
		otu_mode_t  md;
		logic [2:0] code;
		int         n, per, m;
		arst_n = 1'b0;
		training_enable = 1'b0;
		training_revert = 1'b0;
		fault_clear = 1'b0;
		psi5_phase1 = 1'b0;
		run = 1'b0;
		link_mode = MODE_SPI;
		command_period_sel = 2'h0;
		periodic_period_sel = 3'h0;
		fault_count_limit = 7'h02;
		period_cycles = 10'h0c8;
		block_delay = 4'h0;
		exp_trim = 8'sh00;
		repeat (10) @(negedge clk_sys);
		arst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		link_mode = MODE_PSI5;
		training_enable = 1'b1;
		repeat (8) @(negedge clk_sys);
		chk_bit(training_active, 1'b0);
		repeat (16) @(negedge clk_sys);
		chk_bit(training_active, 1'b1);
		training_enable = 1'b0;
		repeat (2) @(negedge clk_sys);
		for (int b = 0; b < 10; b++) begin
			md = otu_mode_t'(b % 5);
			code = 3'($unsigned($random(seed)) % ((md == MODE_DSI3_CRM) ? 2 : 8));
			link_mode = md;
			command_period_sel = code[1:0];
			periodic_period_sel = code;
			fault_count_limit = 7'(1 + $unsigned($random(seed)) % 3);
			psi5_phase1 = 1'($random(seed));
			block_delay = (md < MODE_SPI) ? 4'h3 : 4'h0;
			n = 4000 / per_us(code);
			per = (TYP + corner[0]) / n;
			period_cycles = 10'(per);
			exp_fault = 0;
			exp_flag = 1'b0;
			training_enable = 1'b1;
			run = 1'b1;
			for (int i = 0; i < 6; i++) begin
				wait_done();
				m = n * per;
				per = (TYP + ((i < 3) ? corner[i + 1] : $random(seed) % 65)) / n;
				period_cycles = 10'(per);
				chk_val(measured_count, m);
				chk_bit(training_active, 1'b1);
				chk_bit(sync_reply_block, md == MODE_PSI5 && psi5_phase1);
				chk_bit(training_fault_flag, exp_flag);
				if (m < TYP - WIN || m > TYP + WIN) exp_fault = (exp_fault < 127) ? exp_fault + 1 : 127;
				else exp_fault = (exp_fault > 0) ? exp_fault - 1 : 0;
				chk_val(fault_count, exp_fault);
				exp_flag = exp_flag | (exp_fault >= fault_count_limit);
				nt = next_trim(m, exp_trim);
				if (md >= MODE_SPI) begin
					chk_val(trim_offset, nt);
				end else begin
					chk_val(trim_offset, exp_trim);
					repeat (3) @(negedge clk_sys);
					chk_val(trim_offset, nt);
				end
				exp_trim = nt;
			end
			// One more edge lets a limit reached by the last measurement raise the flag.
			@(negedge clk_sys);
			training_revert = 1'(b);
			training_enable = 1'b0;
			run = 1'b0;
			repeat (2) @(negedge clk_sys);
			if (b % 2 == 1) exp_trim = 8'sh00;
			chk_val(trim_offset, exp_trim);
			chk_val(fault_count, 0);
			chk_bit(training_fault_flag, exp_flag);
			fault_clear = 1'b1;
			@(negedge clk_sys);
			fault_clear = 1'b0;
			@(negedge clk_sys);
			chk_bit(training_fault_flag, 1'b0);
		end
		// Codes 3 and 2 of the shortened table hold 3000 us and 250 us.
		training_revert = 1'b0;
		link_mode = MODE_DSI3_CRM;
		period_cycles = 10'h032;
		for (int c = 2; c < 4; c++) begin
			command_period_sel = 2'(c);
			training_enable = 1'b1;
			run = 1'b1;
			repeat (300) @(negedge clk_sys);
			chk_bit(training_fault_flag, 1'b1);
			chk_bit(training_active, 1'b0);
			chk_val(trim_offset, exp_trim);
			training_enable = 1'b0;
			run = 1'b0;
			fault_clear = 1'b1;
			@(negedge clk_sys);
			fault_clear = 1'b0;
			@(negedge clk_sys);
		end
		end_of_test();
	end
endmodule : tb
`default_nettype wire
